/* File: core/agsc_addr_gen.sv */
`timescale 1ns/10ps
// Function
// - Stack pointer addresses first free word, upward
// - Push writes then increments; pop decrements first
// - Call push clears program counter top bit
// - Exception push merges status low byte
// - Stack limit unset at reset, bit0 zero
// - Stack pointer addresses compared against limit
// - Push at limit allowed; next push traps
// - Stack address below floor raises underflow trap
// - Boot secure RAM only from boot code
// - Secure segment RAM only from secure code
// - File direct address is 13 bits, near
// - File instructions default to working register zero
// - Move instruction reaches whole data space
// - Base register direct; second register or literal
// - Five or ten bit literals plus modes
// - File direct uses address field unchanged
// - Register direct returns contents, no memory
// - Indirect address equals pointer contents
// - Post-modify uses pointer, then updates it
// - Pre-modify adjusts pointer, result is address
// - Register offset adds pointer and base
module agsc_addr_gen
    import agsc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Decoder request
    input wire agsc_req_t req,
    // Stack limit write port
    input wire logic limit_wr,
    input wire logic [DATA_W-1:0] limit_wdata,
    // Protected regions
    input wire agsc_region_t boot_secure_ram,
    input wire agsc_region_t secure_segment_ram,
    // Stack pointer write from the pipeline
    input wire logic sp_wr,
    input wire logic [DATA_W-1:0] sp_wdata,
    // Results
    output agsc_resp_t resp,
    output logic [DATA_W-1:0] stack_pointer_reg,
    output logic [DATA_W-1:0] stack_limit_reg,
    output logic stack_trap,
    output logic stack_underflow,
    output logic seg_violation
);

    agsc_resp_t resp_q, resp_d;
    logic [DATA_W-1:0] sp_q, sp_d;
    logic [DATA_W-1:0] limit_q, limit_d;
    logic trap_q, trap_d;
    logic under_q, under_d;
    logic segv_q, segv_d;

    // Byte operations step by one, word operations by two.
    wire [DATA_W-1:0] step = req.byte_op ? BYTE_STEP : WORD_STEP;
    wire is_sp_ptr = req.ptr_sel == SP_INDEX;
    wire [DATA_W-1:0] ptr = is_sp_ptr ? sp_q : req.ptr_val;
    wire [DATA_W-1:0] ptr_inc = ptr + step;
    wire [DATA_W-1:0] ptr_dec = ptr - step;
    wire [DATA_W-1:0] sp_pop = sp_q - WORD_STEP;
    wire [DATA_W-1:0] sp_push_nx = sp_q + WORD_STEP;

    // Near space address, zero-extended.
    wire [DATA_W-1:0] file_ea = {{(DATA_W-FADDR_W){1'b0}}, req.file_addr};
    wire [DATA_W-1:0] lit5_val = {{(DATA_W-LIT5_W){1'b0}}, req.literal[LIT5_W-1:0]};
    wire [DATA_W-1:0] lit10_val = {{(DATA_W-LIT10_W){1'b0}}, req.literal};

    // The counter's top bit is dropped; a call push's upper word holds counter bits 21:16, zero-filled above, so bit 15 is never set.
    wire [DATA_W-1:0] hi_call = {{(2*DATA_W-PC_W+1){1'b0}},
        req.pc[PC_W-2:DATA_W]};
    wire [DATA_W-1:0] hi_exc = {req.status_low_byte, 2'h0, req.pc[PC_W-2:DATA_W]};

    wire is_push = req.mode inside {AM_PUSH, AM_PUSH_PC_CALL, AM_PUSH_PC_EXC};
    wire is_pop = req.mode == AM_POP;
    wire pc_push = req.mode inside {AM_PUSH_PC_CALL, AM_PUSH_PC_EXC};

    logic [DATA_W-1:0] ea;
    logic mem;
    logic [DATA_W-1:0] operand;
    logic wb_en;
    logic [DATA_W-1:0] wb_val;
    logic [DATA_W-1:0] sp_after;
    logic uses_sp;

    always_comb begin
        ea = ZERO16;
        mem = 1'b1;
        operand = ZERO16;
        wb_en = 1'b0;
        wb_val = ptr;
        sp_after = sp_q;
        uses_sp = 1'b0;
        case (req.mode)
            AM_FILE_DIRECT: begin
                // A move may carry a full data-space address in its pointer value.
                ea = req.move_op ? req.ptr_val : file_ea;
            end
            AM_REG_DIRECT: begin
                mem = 1'b0;
                operand = ptr;
            end
            AM_REG_INDIRECT: begin
                ea = ptr;
                uses_sp = is_sp_ptr;
            end
            AM_POST_INC: begin
                ea = ptr;
                wb_en = 1'b1;
                wb_val = ptr_inc;
                uses_sp = is_sp_ptr;
            end
            AM_POST_DEC: begin
                ea = ptr;
                wb_en = 1'b1;
                wb_val = ptr_dec;
                uses_sp = is_sp_ptr;
            end
            AM_PRE_INC: begin
                ea = ptr_inc;
                wb_en = 1'b1;
                wb_val = ptr_inc;
                uses_sp = is_sp_ptr;
            end
            AM_PRE_DEC: begin
                ea = ptr_dec;
                wb_en = 1'b1;
                wb_val = ptr_dec;
                uses_sp = is_sp_ptr;
            end
            AM_REG_OFFSET: begin
                ea = ptr + req.base_val;
                uses_sp = is_sp_ptr;
            end
            AM_LIT_OFFSET: begin
                ea = ptr + req.lit_offset;
                uses_sp = is_sp_ptr;
            end
            AM_LIT5: begin
                mem = 1'b0;
                operand = lit5_val;
            end
            AM_LIT10: begin
                mem = 1'b0;
                operand = lit10_val;
            end
            AM_POP: begin
                ea = sp_pop;
                sp_after = sp_pop;
                uses_sp = 1'b1;
            end
            default: begin
                // All push forms write at the free word then advance.
                ea = sp_q;
                sp_after = sp_push_nx;
                uses_sp = 1'b1;
            end
        endcase
        if (wb_en && is_sp_ptr) begin
            sp_after = wb_val;
        end
    end

    // Limit check: the push landing exactly on the limit is legal.
    wire over = uses_sp && (ea > limit_q);
    wire under = uses_sp && (ea < STACK_FLOOR);
    wire stack_fault = req.valid && (over || under);

    wire seg_block;

    agsc_seg_guard u_guard (
        .addr(ea),
        .active(req.valid && mem),
        .code_seg(req.code_seg),
        .boot_secure_ram(boot_secure_ram),
        .secure_segment_ram(secure_segment_ram),
        .blocked(seg_block)
    );

    wire accept = req.valid && !stack_fault && !seg_block;
    wire [DATA_W-1:0] lo_word = pc_push ? req.pc[DATA_W-1:0] : ZERO16;
    wire [DATA_W-1:0] hi_word = req.mode == AM_PUSH_PC_EXC ? hi_exc : hi_call;

    always_comb begin
        resp_d = '0;
        resp_d.valid = req.valid;
        resp_d.mem_access = accept && mem;
        resp_d.effective_address = ea;
        resp_d.operand = req.mode == AM_REG_DIRECT && req.ptr_sel == SP_INDEX ? sp_q
            : operand;
        resp_d.wb_en = accept && wb_en && !is_sp_ptr;
        resp_d.wb_sel = req.ptr_sel;
        resp_d.wb_val = wb_val;
        resp_d.default_working_reg = WREG0_INDEX;
        resp_d.push_hi_word = pc_push ? hi_word : ZERO16;
        resp_d.push_lo_word = lo_word;
    end

    always_comb begin
        sp_d = sp_q;
        if (sp_wr) begin
            sp_d = sp_wdata & ALIGN_MASK;
        end else if (accept && (is_push || is_pop || (wb_en && is_sp_ptr))) begin
            sp_d = sp_after;
        end
        // The limit has no reset; it holds until software writes it.
        limit_d = limit_wr ? (limit_wdata & ALIGN_MASK) : limit_q;
        trap_d = stack_fault;
        under_d = req.valid && under;
        segv_d = seg_block;
    end

    always_ff @(posedge core_clk) begin
        limit_q <= limit_d;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            resp_q <= '0;
            sp_q <= STACK_FLOOR;
            trap_q <= 1'b0;
            under_q <= 1'b0;
            segv_q <= 1'b0;
        end else begin
            resp_q <= resp_d;
            sp_q <= sp_d;
            trap_q <= trap_d;
            under_q <= under_d;
            segv_q <= segv_d;
        end
    end

    assign resp = resp_q;
    assign stack_pointer_reg = sp_q;
    assign stack_limit_reg = limit_q;
    assign stack_trap = trap_q;
    assign stack_underflow = under_q;
    assign seg_violation = segv_q;

endmodule : agsc_addr_gen

/* File: core/agsc_pkg.sv */
package agsc_pkg;

    localparam int DATA_W = 16;
    localparam int FADDR_W = 13;
    localparam int LIT5_W = 5;
    localparam int LIT10_W = 10;
    localparam int PC_W = 23;

    // Lowest address the stack may use; below it lies the special register space.
    localparam logic [15:0] STACK_FLOOR = 16'h0800;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam logic [15:0] ALIGN_MASK = 16'hFFFE;
    localparam logic [15:0] BYTE_STEP = 16'h0001;
    localparam logic [3:0] SP_INDEX = 4'hF;
    localparam logic [3:0] WREG0_INDEX = 4'h0;
    localparam logic [15:0] ZERO16 = 16'h0000;

    typedef enum logic [3:0] {
        AM_FILE_DIRECT,
        AM_REG_DIRECT,
        AM_REG_INDIRECT,
        AM_POST_INC,
        AM_POST_DEC,
        AM_PRE_INC,
        AM_PRE_DEC,
        AM_REG_OFFSET,
        AM_LIT_OFFSET,
        AM_LIT5,
        AM_LIT10,
        AM_PUSH,
        AM_POP,
        AM_PUSH_PC_CALL,
        AM_PUSH_PC_EXC
    } agsc_mode_t;

    typedef enum logic [1:0] {
        SEG_GENERAL,
        SEG_BOOT,
        SEG_SECURE
    } agsc_seg_t;

    // One operand request from the decoder.
    typedef struct packed {
        logic valid;
        agsc_mode_t mode;
        logic byte_op;
        logic move_op;
        logic [3:0] ptr_sel;
        logic [DATA_W-1:0] ptr_val;
        logic [DATA_W-1:0] base_val;
        logic [FADDR_W-1:0] file_addr;
        logic [LIT10_W-1:0] literal;
        logic [DATA_W-1:0] lit_offset;
        logic [PC_W-1:0] pc;
        logic [7:0] status_low_byte;
        agsc_seg_t code_seg;
    } agsc_req_t;

    // Resolved operand toward the execution pipeline.
    typedef struct packed {
        logic valid;
        logic mem_access;
        logic [DATA_W-1:0] effective_address;
        logic [DATA_W-1:0] operand;
        logic wb_en;
        logic [3:0] wb_sel;
        logic [DATA_W-1:0] wb_val;
        logic [3:0] default_working_reg;
        logic [DATA_W-1:0] push_hi_word;
        logic [DATA_W-1:0] push_lo_word;
    } agsc_resp_t;

    typedef struct packed {
        logic enable;
        logic [DATA_W-1:0] lo;
        logic [DATA_W-1:0] hi;
    } agsc_region_t;

endpackage : agsc_pkg

/* File: core/agsc_seg_guard.sv */
`timescale 1ns/10ps
module agsc_seg_guard
    import agsc_pkg::*;
(
    // Access under test
    input wire logic [DATA_W-1:0] addr,
    input wire logic active,
    input wire agsc_seg_t code_seg,
    // Protected regions
    input wire agsc_region_t boot_secure_ram,
    input wire agsc_region_t secure_segment_ram,
    // Result
    output logic blocked
);

    wire in_boot = boot_secure_ram.enable && addr >= boot_secure_ram.lo
        && addr <= boot_secure_ram.hi;
    wire in_sec = secure_segment_ram.enable && addr >= secure_segment_ram.lo
        && addr <= secure_segment_ram.hi;
    wire boot_bad = in_boot && code_seg != SEG_BOOT;
    wire sec_bad = in_sec && code_seg != SEG_SECURE;

    assign blocked = active && (boot_bad || sec_bad);

endmodule : agsc_seg_guard

/* File: test/agsc_checker.sv */
`timescale 1ns/10ps
module agsc_checker
    import agsc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Stimulus side
    input wire agsc_req_t req,
    input wire logic limit_wr,
    input wire logic [DATA_W-1:0] limit_wdata,
    input wire logic sp_wr,
    // Results
    input wire agsc_resp_t resp,
    input wire logic [DATA_W-1:0] stack_pointer_reg,
    input wire logic [DATA_W-1:0] stack_limit_reg,
    input wire logic stack_trap,
    input wire logic stack_underflow,
    input wire logic seg_violation
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Pointer writes in the same cycle would mask the update, so they are left out.
    wire logic calm = req.valid && !sp_wr && !limit_wr;
    wire logic [15:0] sp = stack_pointer_reg;
    wire logic [15:0] sp_dn = stack_pointer_reg - WORD_STEP;
    sequence s_push_ok;
        calm && req.mode == AM_PUSH && sp <= stack_limit_reg && sp >= STACK_FLOOR;
    endsequence
    sequence s_pop_ok;
        calm && req.mode == AM_POP && sp_dn <= stack_limit_reg && sp_dn >= STACK_FLOOR;
    endsequence
    property p_push;
        s_push_ok |=> resp.mem_access && resp.effective_address == $past(sp)
            && sp == $past(sp) + WORD_STEP;
    endproperty
    a_push: assert property (p_push) else $error("push step wrong");
    property p_pop;
        s_pop_ok |=> resp.effective_address == $past(sp_dn) && sp == $past(sp_dn);
    endproperty
    a_pop: assert property (p_pop) else $error("pop step wrong");
    property p_over;
        calm && req.mode == AM_PUSH && sp > stack_limit_reg
            |=> stack_trap && !resp.mem_access && $stable(sp);
    endproperty
    a_over: assert property (p_over) else $error("overflow not trapped");
    property p_under;
        calm && req.mode == AM_POP && sp_dn < STACK_FLOOR |=> stack_underflow && stack_trap;
    endproperty
    a_under: assert property (p_under) else $error("underflow not trapped");
    property p_sup;
        stack_trap || seg_violation |-> !resp.mem_access && !resp.wb_en;
    endproperty
    a_sup: assert property (p_sup) else $error("faulting access not suppressed");
    property p_limit;
        limit_wr |=> stack_limit_reg == ($past(limit_wdata) & ALIGN_MASK);
    endproperty
    a_limit: assert property (p_limit) else $error("limit write wrong");
    property p_call;
        req.valid && req.mode == AM_PUSH_PC_CALL
            |=> !resp.push_hi_word[15] && resp.push_lo_word == $past(req.pc[15:0]);
    endproperty
    a_call: assert property (p_call) else $error("call push words wrong");
    property p_exc;
        req.valid && req.mode == AM_PUSH_PC_EXC
            |=> resp.push_hi_word[15:8] == $past(req.status_low_byte);
    endproperty
    a_exc: assert property (p_exc) else $error("exception push words wrong");
    property p_dir;
        req.valid && req.mode == AM_REG_DIRECT
            |=> resp.valid && !resp.mem_access && resp.default_working_reg == WREG0_INDEX;
    endproperty
    a_dir: assert property (p_dir) else $error("register direct wrong");
endmodule : agsc_checker

/* File: test/agsc_dec_model.sv */
`timescale 1ns/10ps
module agsc_dec_model
    import agsc_pkg::*;
(
    // Operation from the bench
    input wire logic go,
    input wire agsc_mode_t mode,
    input wire logic [3:0] sel,
    input wire logic [DATA_W-1:0] ptr,
    input wire logic [DATA_W-1:0] base,
    input wire agsc_seg_t seg,
    // Request toward the block
    output agsc_req_t req
);
    // The program counter and status byte reuse operand fields to save bench inputs.
    assign req = '{valid: go, mode: mode, byte_op: 1'b0, move_op: 1'b0, ptr_sel: sel,
        ptr_val: ptr, base_val: base, file_addr: ptr[12:0], literal: base[9:0],
        lit_offset: ZERO16, pc: {ptr[6:0], base}, status_low_byte: base[15:8],
        code_seg: seg};
endmodule : agsc_dec_model

/* File: test/tb.sv */
`timescale 1ns/10ps
module tb
    import agsc_pkg::*;
();
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic go = 1'b0, limit_wr = 1'b0, sp_wr = 1'b0;
    agsc_mode_t mode = AM_REG_DIRECT;
    agsc_seg_t seg = SEG_GENERAL;
    logic [3:0] sel = 4'h3;
    logic [15:0] ptr = 16'h0000, base = 16'h0000, lim_d = 16'h0000, sp_d = 16'h0000;
    logic [15:0] r = 16'h1C94;
    agsc_req_t req;
    agsc_resp_t resp;
    agsc_region_t boot_r = '{1'b1, 16'h2000, 16'h20FF};
    agsc_region_t sec_r = '{1'b1, 16'h3000, 16'h30FF};
    agsc_mode_t ml[5] = '{AM_FILE_DIRECT, AM_REG_DIRECT, AM_REG_INDIRECT, AM_POST_INC,
        AM_REG_OFFSET};
    logic [15:0] spq, limq;
    logic trap, undf, segv;
    int sp_m = 'h800, lim_m = 0, bad_count = 0, num_checks = 0;
    always #5 core_clk = ~core_clk;
    agsc_dec_model u_dec (.go(go), .mode(mode), .sel(sel), .ptr(ptr), .base(base),
        .seg(seg), .req(req));
    agsc_addr_gen u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .req(req),
        .limit_wr(limit_wr), .limit_wdata(lim_d), .boot_secure_ram(boot_r),
        .secure_segment_ram(sec_r), .sp_wr(sp_wr), .sp_wdata(sp_d), .resp(resp),
        .stack_pointer_reg(spq), .stack_limit_reg(limq), .stack_trap(trap),
        .stack_underflow(undf), .seg_violation(segv));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic wr(input logic is_lim, input logic [15:0] v);
        @(posedge core_clk);
        limit_wr <= is_lim;
        sp_wr <= !is_lim;
        lim_d <= v;
        sp_d <= v;
        @(posedge core_clk);
        limit_wr <= 1'b0;
        sp_wr <= 1'b0;
        @(posedge core_clk);
        #1;
        lim_m = is_lim ? v & 'hFFFE : lim_m;
        sp_m = is_lim ? sp_m : v & 'hFFFE;
        chk((is_lim ? limq : spq) === (v & ALIGN_MASK), "pointer write");
    endtask : wr
    task automatic op(input agsc_mode_t m, input logic [3:0] s, input logic [15:0] p, b,
            input agsc_seg_t g);
        int ea;
        logic tr, blk, mem;
        ea = m == AM_PUSH ? sp_m : m == AM_POP ? sp_m - 2 : m == AM_REG_OFFSET ? p + b
            : m == AM_FILE_DIRECT ? p % 8192 : p;
        tr = s == SP_INDEX && (ea > lim_m || ea < 2048);
        blk = ea >= 'h2000 && ea <= 'h20FF && g != SEG_BOOT
            || ea >= 'h3000 && ea <= 'h30FF && g != SEG_SECURE;
        mem = m != AM_REG_DIRECT && !tr && !blk;
        @(posedge core_clk);
        go <= 1'b1;
        mode <= m;
        sel <= s;
        ptr <= p;
        base <= b;
        seg <= g;
        @(posedge core_clk);
        go <= 1'b0;
        #1;
        if (m < AM_PUSH_PC_CALL) begin
            chk(resp.valid === 1'b1 && trap === tr && segv === blk && resp.mem_access === mem
                && resp.default_working_reg === WREG0_INDEX, "flags");
            chk(undf === (tr && ea < 2048), "underflow flag");
            if (m != AM_REG_DIRECT) chk(resp.effective_address === ea[15:0], "address");
            if (m == AM_REG_DIRECT) chk(resp.operand === p, "operand");
            if (m == AM_POST_INC) chk(resp.wb_val === p + 16'h0002, "post step");
            sp_m = mem && m == AM_PUSH ? sp_m + 2 : mem && m == AM_POP ? sp_m - 2 : sp_m;
            chk(spq === sp_m[15:0], "stack pointer");
        end
        if (m == AM_PUSH_PC_CALL) chk(resp.push_hi_word === {10'h000, p[5:0]}
            && resp.push_lo_word === b, "call words");
        if (m == AM_PUSH_PC_EXC) chk(resp.push_hi_word[15:8] === b[15:8], "exc words");
    endtask : op
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        chk(spq === STACK_FLOOR && trap === 1'b0, "reset state");
        wr(1'b1, 16'h1001);
        wr(1'b0, 16'h0FFC);
        repeat (4) op(AM_PUSH, SP_INDEX, 16'h0000, 16'h0000, SEG_GENERAL);
        wr(1'b0, 16'h0802);
        repeat (2) op(AM_POP, SP_INDEX, 16'h0000, 16'h0000, SEG_GENERAL);
        $display("stack test done");
        for (int i = 0; i < 20; i++) begin
            r = lfsr(r);
            op(ml[i % 5], 4'h3, i % 5 == 0 ? r : (16'h1000 | (r & 16'h07FE)),
                {8'h00, r[7:1], 1'b0}, SEG_GENERAL);
        end
        $display("mode test done");
        for (int k = 0; k < 6; k++) begin
            op(AM_REG_INDIRECT, 4'h3, k < 3 ? 16'h2010 : 16'h3010, 16'h0000,
                agsc_seg_t'(k % 3));
        end
        $display("segment test done");
        wr(1'b0, 16'h0900);
        op(AM_PUSH_PC_CALL, SP_INDEX, 16'h007F, 16'hA55A, SEG_GENERAL);
        op(AM_PUSH_PC_EXC, SP_INDEX, 16'h007F, 16'hC33C, SEG_GENERAL);
        $display("program counter test done");
        final_report();
    end
    // A hung run is cut short here and counted as a mismatch.
    initial begin
        repeat (3000) @(posedge core_clk);
        bad_count++;
        final_report();
    end
endmodule : tb
bind agsc_addr_gen agsc_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .req(req),
    .limit_wr(limit_wr), .limit_wdata(limit_wdata), .sp_wr(sp_wr), .resp(resp),
    .stack_pointer_reg(stack_pointer_reg), .stack_limit_reg(stack_limit_reg),
    .stack_trap(stack_trap), .stack_underflow(stack_underflow),
    .seg_violation(seg_violation));
